//--- src/dac_pkg.sv
// Shared constants and carrier types for the two-wire DAC slave front end
package dac_pkg;

  // ==========================================================
  // Addressing
  localparam logic [3:0] DAC_ADDR_PREFIX = 4'h4;   // Upper four address bits
  localparam logic [6:0] DAC_SYNC_ADDR = 7'h7E;    // Shared sync address
  localparam logic [2:0] DAC_FIXED_LOW_0 = 3'h0;   // Fixed low bits, variant 0
  localparam logic [2:0] DAC_FIXED_LOW_1 = 3'h1;   // Fixed low bits, variant 1
  localparam logic [2:0] DAC_FIXED_LOW_2 = 3'h2;   // Fixed low bits, variant 2

  // ==========================================================
  // Command byte field positions
  localparam int DAC_CMD_SYNC_BIT = 0;             // sync_update_select
  localparam int DAC_CMD_PDN_BIT = 1;              // power_down_request
  localparam int DAC_CMD_BG_BIT = 2;               // bandgap_ref_select

  // ==========================================================
  // Code layout and reset values
  localparam int DAC_CODE_WIDTH = 10;              // DAC code width
  localparam logic [7:0] DAC_BYTE_RESET = 8'h00;   // Input register reset
  localparam logic [9:0] DAC_CODE_RESET = 10'h000; // Output code reset
  localparam logic [2:0] DAC_LAST_BIT = 3'h7;      // Index of last data bit

  // ==========================================================
  // Synchroniser lanes: scl, sda, link bit, address pins 0..2
  localparam int DAC_SYNC_W = 6;
  localparam logic [5:0] DAC_SYNC_RESET = 6'h03;   // Bus lines idle high

  // ==========================================================
  // Transfer phases
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_ADDR,
    PH_CMD,
    PH_LOW,
    PH_HIGH,
    PH_DONE
  } dac_phase_type;

  // Values presented to the analog side
  typedef struct packed {
    logic [9:0] code;
    logic powerDown;
    logic bandgapSel;
  } dac_out_type;

  // Whole state of the system-clock side
  typedef struct packed {
    dac_phase_type phase;
    logic [2:0] bitCnt;
    logic [7:0] shiftReg;
    logic inAck;
    logic ackDone;
    logic sampleDue;
    logic addrWasSync;
    logic syncRw;
    logic touched;
    logic [7:0] cmdIn;
    logic [7:0] lowIn;
    logic [7:0] highIn;
    logic [7:0] lowPend;
    dac_out_type outs;
    logic sdaOe;
    logic sdaOut;
    logic sclPrev;
    logic sdaPrev;
  } dac_state_type;

  // State of the link-clock side
  typedef struct packed {
    logic bitSample;
  } dac_link_type;

endpackage

//--- src/dac_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps

module dac_sync3 import dac_pkg::*; #(
  parameter int W = DAC_SYNC_W,
  parameter logic [W-1:0] RESET_VAL = DAC_SYNC_RESET
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] filtered
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [W-1:0] s1;   // Metastability catcher, read only by s2
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;  // Accepted level
  } dac_sync_type;

  dac_sync_type st;
  dac_sync_type next_st;
  logic [W-1:0] nextLvl;

  // ==========================================================
  // Per-lane filter: a change counts once s2 and s3 agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_lane
      assign nextLvl[i] = (st.s2[i] == st.s3[i]) ? st.s3[i] : st.lvl[i];
    end
  endgenerate

  // Next state
  always_comb begin
    next_st = st;
    next_st.s1 = asyncIn;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.lvl = nextLvl;
  end

  // Registers, reset to the idle levels
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '{RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
    end else begin
      st <= next_st;
    end
  end

  assign filtered = st.lvl;

endmodule // dac_sync3

//--- src/dac_smbus_slave.sv
// Receive-only two-wire slave front end of a 10-bit DAC
//
// Contract
// - Receive only; quick, send byte, write word.
// - START is SDA falling with SCL high.
// - STOP is SDA rising with SCL high.
// - Slave holds SDA low through acknowledge pulse.
// - Write word: address, command, low, high, STOP.
// - Capture command, low, high on each acknowledge.
// - Sync select clear: STOP copies inputs out.
// - Address is 0100 plus three pin levels.
// - Pinless variants use one fixed low field.
// - Command bit 0 selects sync-address update.
// - Sync update on acknowledge rising SCL edge.
// - Command bit 1 power-down, effective at STOP.
// - Command bit 2 bandgap reference; 7..3 ignored.
// - Code is high bits 1..0 over low byte.
// - Send byte changes only the command register.
// - Interrupted data bytes dropped, command kept.
// - Interrupted command byte is dropped.
// - Data bits sampled on rising SCL.
// - Acknowledge sync address quick command too.
// - Sync with bit 0 clears; 1 conditional update.
`timescale 1ns/10ps

module dac_smbus_slave import dac_pkg::*; #(
  parameter logic HAS_PINS = 1'b1,                // Address pins fitted
  parameter logic [2:0] FIXED_LOW = DAC_FIXED_LOW_0 // Pinless low bits
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclClk,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic addrSelectPin0,
  input wire logic addrSelectPin1,
  input wire logic addrSelectPin2,
  output logic [9:0] dacCode,
  output logic powerDownActive,
  output logic bandgapRefActive
);

  // ==========================================================
  // Declarations
  dac_state_type st;          // Registered state, system clock
  dac_state_type next_st;     // Its next value
  dac_link_type lk;           // Registered state, link clock
  dac_link_type next_lk;      // Its next value
  logic [DAC_SYNC_W-1:0] rawIn; // Lanes into the synchroniser
  logic [DAC_SYNC_W-1:0] filt;  // Filtered lanes
  logic sclF;                 // Filtered clock line
  logic sdaF;                 // Filtered data line
  logic bitF;                 // Bit captured on the link clock
  logic [2:0] pinsF;          // Filtered address pins
  logic sclRise;              // Clock line went high
  logic sclFall;              // Clock line went low
  logic startEv;              // START seen
  logic stopEv;               // STOP seen
  logic bitEv;                // A sampled bit is ready to use
  logic [7:0] fullByte;       // Byte including the bit now arriving
  logic ownHit;               // Byte names this slave for writing
  logic syncHit;              // Byte names the shared sync address

  // ==========================================================
  // Functions

  // Slave address from prefix and pins or the fixed field
  function automatic logic [6:0] slaveAddr(input logic [2:0] pins);
    slaveAddr = HAS_PINS ? {DAC_ADDR_PREFIX, pins}
                         : {DAC_ADDR_PREFIX, FIXED_LOW};
  endfunction

  // Output values from the input registers
  function automatic dac_out_type loadOuts(input logic [7:0] cmd,
                                           input logic [7:0] low,
                                           input logic [7:0] high,
                                           input logic pdn);
    loadOuts.code = {high[1:0], low};
    loadOuts.bandgapSel = cmd[DAC_CMD_BG_BIT];
    loadOuts.powerDown = pdn;
  endfunction

  // ==========================================================
  // Link clock domain: one flop that samples data at each rising
  // clock edge. The clock may stop outside frames, so nothing here
  // needs to finish after the last edge.
  always_comb begin
    next_lk = lk;
    next_lk.bitSample = sdaIn;
  end

  always_ff @(posedge sclClk) begin
    lk <= next_lk;
  end

  // ==========================================================
  // Crossing: bus lines, link bit and straps all pass the filter
  assign rawIn = {addrSelectPin2, addrSelectPin1, addrSelectPin0,
                  lk.bitSample, sdaIn, sclClk};

  dac_sync3 #(
    .W(DAC_SYNC_W),
    .RESET_VAL(DAC_SYNC_RESET)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .asyncIn(rawIn),
    .filtered(filt)
  );

  assign sclF = filt[0];
  assign sdaF = filt[1];
  assign bitF = filt[2];
  assign pinsF = filt[5:3];

  // ==========================================================
  // Line events
  assign sclRise = sclF & ~st.sclPrev;
  assign sclFall = ~sclF & st.sclPrev;
  assign startEv = sclF & st.sclPrev & st.sdaPrev & ~sdaF;
  assign stopEv = sclF & st.sclPrev & ~st.sdaPrev & sdaF;
  // The link bit is used one cycle after the filtered rise, so it
  // has had as long as the clock line to settle through the filter.
  assign bitEv = st.sampleDue;
  assign fullByte = {st.shiftReg[6:0], bitF};
  assign ownHit = (fullByte[7:1] == slaveAddr(pinsF)) && !fullByte[0];
  assign syncHit = (fullByte[7:1] == DAC_SYNC_ADDR);

  // ==========================================================
  // Protocol engine
  always_comb begin
    next_st = st;
    next_st.sclPrev = sclF;
    next_st.sdaPrev = sdaF;
    next_st.sampleDue = sclRise;
    if (startEv) begin
      // New frame; partial bytes are lost with the old one
      next_st.phase = PH_ADDR;
      next_st.bitCnt = 3'h0;
      next_st.inAck = 1'b0;
      next_st.ackDone = 1'b0;
      next_st.sdaOe = 1'b0;
      next_st.sampleDue = 1'b0;
      next_st.lowPend = DAC_BYTE_RESET;
    end else if (stopEv) begin
      // End of frame: update only if this slave took part
      if (st.touched && !st.cmdIn[DAC_CMD_SYNC_BIT]) begin
        next_st.outs = loadOuts(st.cmdIn, st.lowIn, st.highIn,
                                st.cmdIn[DAC_CMD_PDN_BIT]);
      end else if (st.touched) begin
        next_st.outs.powerDown = st.cmdIn[DAC_CMD_PDN_BIT];
      end
      next_st.phase = PH_IDLE;
      next_st.touched = 1'b0;
      next_st.inAck = 1'b0;
      next_st.ackDone = 1'b0;
      next_st.sdaOe = 1'b0;
      next_st.lowPend = DAC_BYTE_RESET;
    end else begin
      // Acknowledge: pull low after the eighth bit's falling edge
      if (sclFall && st.inAck && !st.ackDone) begin
        next_st.sdaOe = 1'b1;
      end
      // Release only after the acknowledge pulse has fallen
      if (sclFall && st.ackDone) begin
        next_st.sdaOe = 1'b0;
        next_st.inAck = 1'b0;
        next_st.ackDone = 1'b0;
        next_st.bitCnt = 3'h0;
      end
      if (bitEv && st.phase != PH_IDLE) begin
        if (!st.inAck) begin
          // Data bit, most significant first
          next_st.shiftReg = fullByte;
          next_st.bitCnt = st.bitCnt + 3'h1;
          if (st.bitCnt == DAC_LAST_BIT) begin
            unique case (st.phase)
              PH_ADDR: begin
                if (ownHit || syncHit) begin
                  next_st.inAck = 1'b1;
                  next_st.addrWasSync = syncHit;
                  next_st.syncRw = fullByte[0];
                end else begin
                  next_st.phase = PH_IDLE;
                end
              end
              PH_CMD, PH_LOW, PH_HIGH: begin
                next_st.inAck = 1'b1;
              end
              PH_DONE: begin
                // A write word or sync address ends the frame; extra bytes unanswered
                next_st.phase = PH_IDLE;
              end
              PH_IDLE: begin
                next_st.phase = PH_IDLE;
              end
            endcase
          end
        end else if (!st.ackDone) begin
          // Rising edge of the acknowledge pulse: act on the byte
          next_st.ackDone = 1'b1;
          unique case (st.phase)
            PH_ADDR: begin
              if (st.addrWasSync) begin
                next_st.phase = PH_DONE;
                if (!st.syncRw) begin
                  // Clear everything, whatever the select bit says
                  next_st.cmdIn = DAC_BYTE_RESET;
                  next_st.lowIn = DAC_BYTE_RESET;
                  next_st.highIn = DAC_BYTE_RESET;
                  next_st.lowPend = DAC_BYTE_RESET;
                  next_st.outs = loadOuts(DAC_BYTE_RESET, DAC_BYTE_RESET,
                                          DAC_BYTE_RESET, 1'b0);
                end else if (st.cmdIn[DAC_CMD_SYNC_BIT]) begin
                  next_st.outs = loadOuts(st.cmdIn, st.lowIn, st.highIn,
                                          st.outs.powerDown);
                end
              end else begin
                next_st.phase = PH_CMD;
                next_st.touched = 1'b1;
              end
            end
            PH_CMD: begin
              next_st.cmdIn = st.shiftReg;
              next_st.phase = PH_LOW;
            end
            PH_LOW: begin
              // Held aside until the high byte completes the word
              next_st.lowPend = st.shiftReg;
              next_st.phase = PH_HIGH;
            end
            PH_HIGH: begin
              next_st.lowIn = st.lowPend;
              next_st.highIn = st.shiftReg;
              next_st.phase = PH_DONE;
            end
            PH_DONE, PH_IDLE: begin
              next_st.phase = st.phase;
            end
          endcase
        end
      end
    end
  end

  // Registers; reset leaves code zero and command defaults
  always_ff @(posedge clk) begin
    if (rst) begin
      st.phase <= PH_IDLE;
      st.bitCnt <= 3'h0;
      st.shiftReg <= DAC_BYTE_RESET;
      st.inAck <= 1'b0;
      st.ackDone <= 1'b0;
      st.sampleDue <= 1'b0;
      st.addrWasSync <= 1'b0;
      st.syncRw <= 1'b0;
      st.touched <= 1'b0;
      st.cmdIn <= DAC_BYTE_RESET;
      st.lowIn <= DAC_BYTE_RESET;
      st.highIn <= DAC_BYTE_RESET;
      st.lowPend <= DAC_BYTE_RESET;
      st.outs <= '{DAC_CODE_RESET, 1'b0, 1'b0};
      st.sdaOe <= 1'b0;
      st.sdaOut <= 1'b0;
      st.sclPrev <= 1'b1;
      st.sdaPrev <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs, each straight from a flop
  assign sdaOut = st.sdaOut;
  assign sdaOe = st.sdaOe;
  assign dacCode = st.outs.code;
  assign powerDownActive = st.outs.powerDown;
  assign bandgapRefActive = st.outs.bandgapSel;

  // ==========================================================
  // Assertions
  logic ackAct;   // Acknowledge rising edge acted upon
  assign ackAct = bitEv && st.inAck && !st.ackDone && !startEv && !stopEv;

  property p_ackOnlyInAck;
    @(posedge clk) disable iff (rst) sdaOe |-> st.inAck;
  endproperty
  a_ackOnlyInAck: assert property (p_ackOnlyInAck)
    else $error("SDA driven outside an acknowledge");

  property p_ackStable;
    @(posedge clk) disable iff (rst)
      (sdaOe && sclF && !startEv && !stopEv) |=> (sdaOe || !sclF);
  endproperty
  a_ackStable: assert property (p_ackStable)
    else $error("SDA released while clock high in acknowledge");

  property p_start;
    @(posedge clk) disable iff (rst)
      startEv |=> (st.phase == PH_ADDR) && !sdaOe && (st.bitCnt == 3'h0);
  endproperty
  a_start: assert property (p_start)
    else $error("START did not restart address phase");

  property p_stop;
    @(posedge clk) disable iff (rst)
      stopEv |=> (st.phase == PH_IDLE) && !sdaOe;
  endproperty
  a_stop: assert property (p_stop)
    else $error("STOP did not return to idle");

  property p_stopUpdate;
    @(posedge clk) disable iff (rst)
      (stopEv && st.touched && !st.cmdIn[DAC_CMD_SYNC_BIT])
      |=> dacCode == {$past(st.highIn[1:0]), $past(st.lowIn)};
  endproperty
  a_stopUpdate: assert property (p_stopUpdate)
    else $error("STOP did not load the code");

  property p_foreign;
    @(posedge clk) disable iff (rst)
      (bitEv && !st.inAck && st.phase == PH_ADDR && st.bitCnt == DAC_LAST_BIT
       && !ownHit && !syncHit && !startEv && !stopEv)
      |=> !st.inAck ##1 !sdaOe [*8];
  endproperty
  a_foreign: assert property (p_foreign)
    else $error("Foreign address acknowledged");

  property p_cmdCapture;
    @(posedge clk) disable iff (rst)
      (ackAct && st.phase == PH_CMD)
      |=> st.cmdIn == $past(st.shiftReg) && st.phase == PH_LOW;
  endproperty
  a_cmdCapture: assert property (p_cmdCapture)
    else $error("Command byte not captured on acknowledge");

  property p_syncClear;
    @(posedge clk) disable iff (rst)
      (ackAct && st.phase == PH_ADDR && st.addrWasSync && !st.syncRw)
      |=> dacCode == DAC_CODE_RESET && st.cmdIn == DAC_BYTE_RESET;
  endproperty
  a_syncClear: assert property (p_syncClear)
    else $error("Sync clear left state behind");

  property p_reset;
    @(posedge clk) rst |=> dacCode == DAC_CODE_RESET && !powerDownActive
      && !bandgapRefActive && !sdaOe;
  endproperty
  a_reset: assert property (p_reset)
    else $error("Reset values wrong");

  c_writeWord: cover property (@(posedge clk) disable iff (rst)
    ackAct && st.phase == PH_HIGH);
  c_syncClear: cover property (@(posedge clk) disable iff (rst)
    ackAct && st.addrWasSync && !st.syncRw);
  c_sendByte: cover property (@(posedge clk) disable iff (rst)
    stopEv && st.phase == PH_LOW);

endmodule // dac_smbus_slave

//--- bench/dac_bus_master.sv
// Bus master model that drives the two-wire clock and data lines
`timescale 1ns/10ps

module dac_bus_master (
  output logic sclLine,
  output logic sdaPullLow,
  input wire logic sdaLine
);
  // ======================================================
  // Line control
  // Both lines released between frames; the clock stands still then
  initial begin
    sclLine = 1'b1;
    sdaPullLow = 1'b0;
  end

  // START, or repeated START from the low phase of a frame
  task automatic start();
    if (!sclLine) begin
      #40 sdaPullLow = 1'b0;
      #40 sclLine = 1'b1;
      #80;
    end else begin
      // Odd offset keeps the link clock out of step with clk
      #1.3;
    end
    sdaPullLow = 1'b1;
    #80 sclLine = 1'b0;
  endtask

  // STOP: data rises while the clock is high, then bus free time
  task automatic stop();
    #40 sdaPullLow = 1'b1;
    #40 sclLine = 1'b1;
    #80 sdaPullLow = 1'b0;
    #200;
  endtask

  // MSB first, data set in mid low phase; n below 8 aborts a byte
  task automatic sendBits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      #40 sdaPullLow = ~b[i];
      #40 sclLine = 1'b1;
      #80 sclLine = 1'b0;
    end
  endtask

  // Ack pulse with data released; low early and late in the high phase
  task automatic ackPulse(output logic ack);
    logic early;
    #40 sdaPullLow = 1'b0;
    #40 sclLine = 1'b1;
    #5 early = sdaLine;
    #70 ack = ~early & ~sdaLine;
    #5 sclLine = 1'b0;
  endtask
endmodule // dac_bus_master

//--- bench/smbus_dac_write_slave_bench.sv
// Self-checking bench for the two-wire DAC slave front end
`timescale 1ns/10ps
`define CHECK(nm, exp, got) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    $display("BAD %s expected %h seen %h", nm, exp, got); \
    error_cnt++; \
  end \
end

module smbus_dac_write_slave_bench import dac_pkg::*;;
  // ======================================================
  // Signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] pins = 3'h5; // Address strap levels
  logic sclLine, masterLow, sdaLine;
  logic sdaOut, sdaOe, sdaOut2, sdaOe2;
  logic [9:0] dacCode, dacCode2;
  logic powerDown, bandgap, powerDown2, bandgap2;
  dac_out_type seenOut, outM, headOut;
  dac_out_type expQ[$]; // Expected output changes, oldest first
  logic [7:0] cmdM = 8'h00, lowM = 8'h00, highM = 8'h00; // Input model
  logic [3:0] acks;
  int error_cnt = 0;
  int samples_checked = 0;
  integer seed = 29967;

  always #5 clk = ~clk;
  // Open drain with pull-up: any party pulling wins
  assign sdaLine = ~(masterLow | (sdaOe & ~sdaOut) | (sdaOe2 & ~sdaOut2));
  assign seenOut = {dacCode, powerDown, bandgap};

  // ======================================================
  // Parties on the bus
  dac_bus_master u_master (.sclLine(sclLine), .sdaPullLow(masterLow),
    .sdaLine(sdaLine));
  dac_smbus_slave u_dut (.clk(clk), .rst(rst), .sclClk(sclLine),
    .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .addrSelectPin0(pins[0]), .addrSelectPin1(pins[1]),
    .addrSelectPin2(pins[2]), .dacCode(dacCode),
    .powerDownActive(powerDown), .bandgapRefActive(bandgap));
  // Pinless variant; its straps are wired but must be ignored
  dac_smbus_slave #(.HAS_PINS(1'b0), .FIXED_LOW(DAC_FIXED_LOW_2))
    u_dut_fixed (.clk(clk), .rst(rst), .sclClk(sclLine),
    .sdaIn(sdaLine), .sdaOut(sdaOut2), .sdaOe(sdaOe2),
    .addrSelectPin0(pins[0]), .addrSelectPin1(pins[1]),
    .addrSelectPin2(pins[2]), .dacCode(dacCode2),
    .powerDownActive(powerDown2), .bandgapRefActive(bandgap2));

  // ======================================================
  // Tasks
  // Address byte plus n bytes {high, low, cmd}; leaves the frame open
  task automatic frame(input logic [6:0] a, input logic rw,
      input logic [23:0] d, input int n);
    logic ack;
    acks = 4'h0;
    u_master.start();
    u_master.sendBits({a, rw}, 8);
    u_master.ackPulse(ack);
    acks[0] = ack;
    for (int i = 0; i < n; i++) begin
      u_master.sendBits(d[8*i +: 8], 8);
      u_master.ackPulse(ack);
      acks[i+1] = ack;
    end
  endtask

  // Note an output change only if it really differs
  task automatic noteOut(input dac_out_type e);
    if (e !== outM) expQ.push_back(e);
    outM = e;
  endtask

  // What a STOP does to the outputs
  task automatic stopUpdate();
    dac_out_type e;
    e = outM;
    e.powerDown = cmdM[DAC_CMD_PDN_BIT];
    if (!cmdM[DAC_CMD_SYNC_BIT]) begin
      e.code = {highM[1:0], lowM};
      e.bandgapSel = cmdM[DAC_CMD_BG_BIT];
    end
    noteOut(e);
  endtask

  // Let updates land, then every noted change must have been seen
  task automatic settle();
    repeat (10) @(negedge clk);
    `CHECK("pending", 0, expQ.size())
    `CHECK("outputs", outM, seenOut)
  endtask

  // Verdict and end of run
  task automatic results();
    $display("Checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ======================================================
  // Output watcher: each change takes the oldest note
  always @(seenOut) begin
    if (!rst) begin
      if (expQ.size() == 0) begin
        $display("BAD outputs expected no change seen %h", seenOut);
        error_cnt++;
      end else begin
        headOut = expQ.pop_front();
        `CHECK("outputs", headOut, seenOut)
      end
    end
  end

  // Watchdog well beyond the roughly 94 us of traffic
  initial begin
    #400000;
    error_cnt++;
    $display("BAD watchdog expected done seen timeout");
    results();
  end

  // ======================================================
  // Main sequence
  initial begin
    dac_out_type z;
    logic [7:0] c, lo, hi;
    logic [6:0] own;
    outM = '0;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    `CHECK("resetOut", 12'h000, seenOut)
    // Write word at every strap setting; junk in ignored bits
    for (int p = 0; p < 8; p++) begin
      pins = p[2:0];
      repeat (8) @(negedge clk);
      own = {DAC_ADDR_PREFIX, pins};
      c = 8'($random(seed)) & 8'hFC;
      lo = 8'($random(seed));
      hi = 8'($random(seed));
      frame(own, 1'b0, {hi, lo, c}, 3);
      `CHECK("wordAcks", 4'hF, acks)
      cmdM = c;
      lowM = lo;
      highM = hi;
      stopUpdate();
      u_master.stop();
      settle();
    end
    // Foreign address and read request stay unanswered
    frame(7'h26, 1'b0, 24'h0000FF, 1);
    `CHECK("foreignAck", 4'h0, acks)
    u_master.stop();
    frame(own, 1'b1, 24'h0000FF, 1);
    `CHECK("readAck", 4'h0, acks)
    u_master.stop();
    settle();
    // Send byte: power-down and bandgap, applied only at STOP
    frame(own, 1'b0, 24'h000006, 1);
    `CHECK("sendAcks", 4'h3, acks)
    `CHECK("earlyPdn", 1'b0, powerDown)
    cmdM = 8'h06;
    stopUpdate();
    u_master.stop();
    settle();
    // Word cut off after a whole low byte by repeated START, then by STOP
    frame(own, 1'b0, {8'h00, ~lowM, 8'h04}, 2);
    frame(own, 1'b0, 24'h000000, 0);
    cmdM = 8'h04;
    stopUpdate();
    u_master.stop();
    settle();
    frame(own, 1'b0, {8'h00, ~lowM, 8'h00}, 2);
    cmdM = 8'h00;
    stopUpdate();
    u_master.stop();
    settle();
    // Command byte cut off after seven bits is dropped
    frame(own, 1'b0, 24'h000000, 0);
    u_master.sendBits(8'h06, 7);
    stopUpdate();
    u_master.stop();
    settle();
    // Sync mode: STOP holds the code, sync address loads it
    lo = 8'($random(seed));
    frame(own, 1'b0, {8'h02, lo, 8'h01}, 3);
    // A fourth data byte goes unanswered
    u_master.sendBits(8'hFF, 8);
    u_master.ackPulse(acks[3]);
    `CHECK("extraAck", 4'h7, acks)
    cmdM = 8'h01;
    lowM = lo;
    highM = 8'h02;
    stopUpdate();
    u_master.stop();
    settle();
    z = outM;
    z.code = {highM[1:0], lowM};
    z.bandgapSel = 1'b0;
    noteOut(z);
    frame(DAC_SYNC_ADDR, 1'b1, 24'h0, 0);
    `CHECK("syncAck", 4'h1, acks)
    `CHECK("syncLoad", outM, seenOut)
    u_master.stop();
    settle();
    // Sync clear empties every latch
    noteOut('0);
    frame(DAC_SYNC_ADDR, 1'b0, 24'h0, 0);
    `CHECK("clearAck", 4'h1, acks)
    cmdM = 8'h00;
    lowM = 8'h00;
    highM = 8'h00;
    u_master.stop();
    settle();
    // Pinless variant answers its fixed address only
    pins = 3'h0;
    repeat (8) @(negedge clk);
    frame(7'h22, 1'b0, 24'h03C304, 3);
    `CHECK("fixedAcks", 4'hF, acks)
    u_master.stop();
    settle();
    `CHECK("fixedCode", 10'h3C3, dacCode2)
    `CHECK("fixedFlags", 2'h1, {powerDown2, bandgap2})
    results();
  end
endmodule // smbus_dac_write_slave_bench
